// ---- include/fgd_pkg.sv ----
package fgd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS      = 4'h0;
    localparam logic [3:0] STAT_OFS      = 4'h4;
    localparam logic [3:0] IRQ_STAT_OFS  = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS  = 4'hC;

    // Control field positions
    localparam int CTRL_BANK_BIT  = 0;
    localparam int CTRL_SIZE_BIT  = 1;
    localparam int CTRL_PREC_BIT  = 2;
    localparam int CTRL_ICE_BIT   = 3;
    localparam int CTRL_OCE_BIT   = 4;
    localparam int CTRL_XLATE_BIT = 5;
    localparam int CTRL_W         = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // Interrupt event bits
    localparam int EV_UNDEF = 0;
    localparam int EV_IC    = 1;
    localparam int EV_OC    = 2;
    localparam int EV_FP    = 3;
    localparam int EV_W     = 4;
    localparam logic [3:0] EV_RST = 4'h0;

    // ------------------------------------------------------------
    // Opcodes and hazard windows
    // ------------------------------------------------------------
    localparam logic [15:0] UNDEF_CODE   = 16'hFFFD;
    localparam logic [15:0] BANK_TGL_CODE = 16'hFBFD;
    localparam logic [15:0] SIZE_TGL_CODE = 16'hF3FD;
    localparam int SHORT_WIN_I = 2;
    localparam int LONG_WIN_I  = 4;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        FGD_OP_NONE      = 4'b0000,
        FGD_OP_MOV_DR_XD = 4'b0001,
        FGD_OP_MOV_XD_DR = 4'b0010,
        FGD_OP_MOV_XD_XD = 4'b0011,
        FGD_OP_LD_XD     = 4'b0100,
        FGD_OP_LD_XD_INC = 4'b0101,
        FGD_OP_LD_XD_IDX = 4'b0110,
        FGD_OP_ST_XD     = 4'b0111,
        FGD_OP_ST_XD_DEC = 4'b1000,
        FGD_OP_ST_XD_IDX = 4'b1001,
        FGD_OP_INNER     = 4'b1010,
        FGD_OP_XFORM     = 4'b1011,
        FGD_OP_BANK_TGL  = 4'b1100,
        FGD_OP_SIZE_TGL  = 4'b1101,
        FGD_OP_UNDEF     = 4'b1110
    } fgd_op_t;

    typedef struct packed {
        fgd_op_t    op;
        logic [3:0] rn;
        logic [3:0] rm;
        logic [3:0] dst;
        logic       undef;
        logic       single_issue;
        logic       fp_wb_block;
        logic       t_write;
        logic       privileged;
    } fgd_dec_t;

endpackage

// ---- verilog/fgd_insn_decoder.sv ----
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module fgd_insn_decoder #(
    parameter int          CLK_PER_I  = 1,
    parameter logic [15:0] TRAP_MASK  = 16'hFF00,
    parameter logic [15:0] TRAP_MATCH = 16'hC300,
    parameter logic [15:0] SLEEP_CODE = 16'h001B,
    parameter logic [15:0] ORR0_CODE  = 16'h200B,
    parameter logic [15:0] CBOP_MASK  = 16'hF0CF,
    parameter logic [15:0] CBOP_MATCH = 16'h0083,
    parameter logic [15:0] TAS_MASK   = 16'hF0FF,
    parameter logic [15:0] TAS_MATCH  = 16'h401B
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [3:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [3:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             insn_valid,
    input  wire logic [15:0]      insn_code,
    input  wire logic             insn_cacheable,
    input  wire logic             insn_translated,
    output logic                  dec_valid,
    output fgd_pkg::fgd_dec_t     dec,
    output logic                  fp_bank_select_bit,
    output logic                  fp_transfer_size_bit,
    output logic                  icache_fill_inhibit,
    output logic                  instruction_tlb_refill_inhibit,
    output logic                  irq
);

    localparam int SHORT_CYC = fgd_pkg::SHORT_WIN_I * CLK_PER_I;
    localparam int LONG_CYC  = fgd_pkg::LONG_WIN_I * CLK_PER_I;
    localparam int CNT_W     = $clog2(LONG_CYC + 1);

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [3:0]  aw_addr_r;
    logic        aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_have_r;
    logic        wr_fire;
    logic [5:0]  ctrl_r;
    logic [3:0]  ev_stat_r;
    logic [3:0]  ev_mask_r;
    logic [3:0]  ev_set;
    logic [CNT_W-1:0] short_cnt_r;
    logic [CNT_W-1:0] long_cnt_r;
    logic        oc_win_r;
    logic        ic_arm_r;
    logic        tlb_arm_r;

    assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r     <= 1'b0;
            aw_addr_r     <= 4'h0;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= fgd_pkg::AXI_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r[1:0] == 2'b00) ? fgd_pkg::AXI_OKAY : fgd_pkg::AXI_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= fgd_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00) ? fgd_pkg::AXI_OKAY : fgd_pkg::AXI_SLVERR;
                unique case (s_axi_araddr)
                    fgd_pkg::CTRL_OFS:     s_axi_rdata <= {26'h0, ctrl_r};
                    fgd_pkg::STAT_OFS:     s_axi_rdata <= {23'h0, tlb_arm_r, ic_arm_r, oc_win_r,
                                                           long_cnt_r != '0, short_cnt_r != '0,
                                                           4'h0};
                    fgd_pkg::IRQ_STAT_OFS: s_axi_rdata <= {28'h0, ev_stat_r};
                    fgd_pkg::IRQ_MASK_OFS: s_axi_rdata <= {28'h0, ev_mask_r};
                    default:               s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------
    logic      is_trap;
    logic      is_sleep;
    logic      is_ffd;
    logic      is_prec_undef;
    logic      is_cbop;
    logic      trig;
    fgd_pkg::fgd_dec_t dec_nxt;

    assign is_trap       = (insn_code & TRAP_MASK) == TRAP_MATCH;
    assign is_sleep      = insn_code == SLEEP_CODE;
    assign is_ffd        = insn_code == fgd_pkg::UNDEF_CODE;
    assign is_prec_undef = ctrl_r[fgd_pkg::CTRL_PREC_BIT] && insn_code[15:12] == 4'hF
                           && insn_code[3:0] == 4'hE;
    assign is_cbop       = ((insn_code & CBOP_MASK) == CBOP_MATCH)
                           || ((insn_code & TAS_MASK) == TAS_MATCH);
    assign trig          = insn_valid && (is_trap || is_sleep || is_ffd);

    always_comb
    begin
        dec_nxt              = '0;
        dec_nxt.op           = fgd_pkg::FGD_OP_NONE;
        dec_nxt.rn           = insn_code[11:8];
        dec_nxt.rm           = insn_code[7:4];
        dec_nxt.dst          = insn_code[11:8];
        dec_nxt.single_issue = insn_code == ORR0_CODE;
        dec_nxt.t_write      = 1'b0;
        dec_nxt.privileged   = 1'b0;
        if (is_ffd || is_prec_undef)
        begin
            dec_nxt.op    = fgd_pkg::FGD_OP_UNDEF;
            dec_nxt.undef = 1'b1;
            dec_nxt.fp_wb_block = insn_code[15:12] == 4'hF && long_cnt_r != '0;
        end
        else if (insn_code == fgd_pkg::BANK_TGL_CODE)
            dec_nxt.op = fgd_pkg::FGD_OP_BANK_TGL;
        else if (insn_code == fgd_pkg::SIZE_TGL_CODE)
            dec_nxt.op = fgd_pkg::FGD_OP_SIZE_TGL;
        else if (insn_code[15:12] == 4'hF && insn_code[7:0] == 8'hED)
        begin
            dec_nxt.op  = fgd_pkg::FGD_OP_INNER;
            dec_nxt.rn  = {insn_code[11:10], 2'b00};
            dec_nxt.rm  = {insn_code[9:8], 2'b00};
            dec_nxt.dst = {insn_code[11:10], 2'b11};
        end
        else if (insn_code[15:12] == 4'hF && insn_code[9:0] == 10'h1FD)
        begin
            dec_nxt.op  = fgd_pkg::FGD_OP_XFORM;
            dec_nxt.rn  = {insn_code[11:10], 2'b00};
            dec_nxt.rm  = 4'h0;
            dec_nxt.dst = {insn_code[11:10], 2'b00};
        end
        else if (insn_code[15:12] == 4'hF && ctrl_r[fgd_pkg::CTRL_SIZE_BIT])
        begin
            casez (insn_code[11:0])
                12'b???1???01100: dec_nxt.op = fgd_pkg::FGD_OP_MOV_DR_XD;
                12'b???0???11100: dec_nxt.op = fgd_pkg::FGD_OP_MOV_XD_DR;
                12'b???1???11100: dec_nxt.op = fgd_pkg::FGD_OP_MOV_XD_XD;
                12'b???1????1000: dec_nxt.op = fgd_pkg::FGD_OP_LD_XD;
                12'b???1????1001: dec_nxt.op = fgd_pkg::FGD_OP_LD_XD_INC;
                12'b???1????0110: dec_nxt.op = fgd_pkg::FGD_OP_LD_XD_IDX;
                12'b???????11010: dec_nxt.op = fgd_pkg::FGD_OP_ST_XD;
                12'b???????11011: dec_nxt.op = fgd_pkg::FGD_OP_ST_XD_DEC;
                12'b???????10111: dec_nxt.op = fgd_pkg::FGD_OP_ST_XD_IDX;
                default:          dec_nxt.op = fgd_pkg::FGD_OP_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Decode output stage
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dec_valid <= 1'b0;
            dec       <= '0;
        end
        else
        begin
            dec_valid <= insn_valid;
            dec       <= insn_valid ? dec_nxt : '0;
        end
    end

    // ------------------------------------------------------------
    // Control register and toggles
    // ------------------------------------------------------------
    logic [5:0] ctrl_nxt;
    logic       ctrl_wr;

    assign ctrl_wr = wr_fire && aw_addr_r == fgd_pkg::CTRL_OFS && w_strb_r[0];

    always_comb
    begin
        ctrl_nxt = ctrl_wr ? w_data_r[5:0] : ctrl_r;
        if (insn_valid && dec_nxt.op == fgd_pkg::FGD_OP_BANK_TGL)
            ctrl_nxt[fgd_pkg::CTRL_BANK_BIT] = !ctrl_nxt[fgd_pkg::CTRL_BANK_BIT];
        if (insn_valid && dec_nxt.op == fgd_pkg::FGD_OP_SIZE_TGL)
            ctrl_nxt[fgd_pkg::CTRL_SIZE_BIT] = !ctrl_nxt[fgd_pkg::CTRL_SIZE_BIT];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r               <= fgd_pkg::CTRL_RST;
            fp_bank_select_bit   <= 1'b0;
            fp_transfer_size_bit <= 1'b0;
        end
        else
        begin
            ctrl_r               <= ctrl_nxt;
            fp_bank_select_bit   <= ctrl_nxt[fgd_pkg::CTRL_BANK_BIT];
            fp_transfer_size_bit <= ctrl_nxt[fgd_pkg::CTRL_SIZE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Hazard windows
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            short_cnt_r <= '0;
            long_cnt_r  <= '0;
            oc_win_r    <= 1'b0;
            ic_arm_r    <= 1'b0;
            tlb_arm_r   <= 1'b0;
        end
        else if (trig)
        begin
            short_cnt_r <= CNT_W'(SHORT_CYC);
            long_cnt_r  <= CNT_W'(LONG_CYC);
            oc_win_r    <= is_ffd && ctrl_r[fgd_pkg::CTRL_OCE_BIT];
            ic_arm_r    <= !is_sleep && ctrl_r[fgd_pkg::CTRL_ICE_BIT] && insn_cacheable;
            tlb_arm_r   <= !is_sleep && ctrl_r[fgd_pkg::CTRL_XLATE_BIT] && insn_translated;
        end
        else
        begin
            if (short_cnt_r != '0)
                short_cnt_r <= short_cnt_r - 1'b1;
            else
            begin
                oc_win_r  <= 1'b0;
                ic_arm_r  <= 1'b0;
                tlb_arm_r <= 1'b0;
            end
            if (long_cnt_r != '0)
                long_cnt_r <= long_cnt_r - 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            icache_fill_inhibit <= 1'b0;
            instruction_tlb_refill_inhibit <= 1'b0;
        end
        else
        begin
            icache_fill_inhibit <= trig ? (!is_sleep && ctrl_r[fgd_pkg::CTRL_ICE_BIT] && insn_cacheable)
                                        : (ic_arm_r && short_cnt_r > 1);
            instruction_tlb_refill_inhibit <= trig ? (!is_sleep && ctrl_r[fgd_pkg::CTRL_XLATE_BIT] && insn_translated)
                                        : (tlb_arm_r && short_cnt_r > 1);
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    logic oc_block;
    assign oc_block = insn_valid && !trig && oc_win_r && short_cnt_r != '0 && is_cbop;

    always_comb
    begin
        ev_set                    = '0;
        ev_set[fgd_pkg::EV_UNDEF] = insn_valid && dec_nxt.undef;
        ev_set[fgd_pkg::EV_IC]    = trig && (ic_arm_r || tlb_arm_r);
        ev_set[fgd_pkg::EV_OC]    = oc_block;
        ev_set[fgd_pkg::EV_FP]    = insn_valid && dec_nxt.fp_wb_block;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ev_stat_r <= fgd_pkg::EV_RST;
            ev_mask_r <= fgd_pkg::EV_RST;
            irq       <= 1'b0;
        end
        else
        begin
            if (wr_fire && aw_addr_r == fgd_pkg::IRQ_STAT_OFS && w_strb_r[0])
                ev_stat_r <= (ev_stat_r & ~w_data_r[3:0]) | ev_set;
            else
                ev_stat_r <= ev_stat_r | ev_set;
            if (wr_fire && aw_addr_r == fgd_pkg::IRQ_MASK_OFS && w_strb_r[0])
                ev_mask_r <= w_data_r[3:0];
            irq <= |(ev_stat_r & ev_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ffd_undef_a: assert property (insn_valid && insn_code == 16'hFFFD |=> dec.undef
                                  && dec.op == fgd_pkg::FGD_OP_UNDEF)
        else $error("FFFD not undefined");
    prec_undef_a: assert property (insn_valid && ctrl_r[2] && insn_code[15:12] == 4'hF
                                   && insn_code[3:0] == 4'hE |=> dec.undef)
        else $error("FxxE not undefined");
    inner_dst_a: assert property (dec_valid && dec.op == fgd_pkg::FGD_OP_INNER
                                  |-> dec.dst == (dec.rn | 4'h3))
        else $error("Inner product destination wrong");
    bank_tgl_a: assert property (insn_valid && insn_code == 16'hFBFD && !ctrl_wr
                                 |=> fp_bank_select_bit != $past(ctrl_r[0])
                                 && fp_transfer_size_bit == $past(ctrl_r[1]))
        else $error("Bank toggle wrong");
    size_tgl_a: assert property (insn_valid && insn_code == 16'hF3FD && !ctrl_wr
                                 |=> ctrl_r[1] != $past(ctrl_r[1])
                                 && ctrl_r[0] == $past(ctrl_r[0]))
        else $error("Size toggle wrong");
    long_win_a: assert property (trig |=> long_cnt_r == CNT_W'(LONG_CYC)
                                 ##1 ($past(trig) || long_cnt_r == CNT_W'(LONG_CYC - 1)))
        else $error("Long window count wrong");
    fp_block_a: assert property (insn_valid && !trig && insn_code[15:12] == 4'hF && dec_nxt.undef
                                 && long_cnt_r != '0 |=> dec.fp_wb_block)
        else $error("FP write not blocked");
    ic_inhibit_a: assert property (trig && !is_sleep && ctrl_r[3] && insn_cacheable
                                   |=> icache_fill_inhibit)
        else $error("Icache fill not inhibited");
    tlb_inhibit_a: assert property (trig && !is_sleep && ctrl_r[5] && insn_translated
                                    |=> instruction_tlb_refill_inhibit)
        else $error("TLB refill not inhibited");
    no_priv_a: assert property (dec_valid |-> !dec.privileged && !dec.t_write)
        else $error("Privileged or T write");
    orr0_single_a: assert property (insn_valid && insn_code == ORR0_CODE
                                    |=> dec.single_issue)
        else $error("OR R0 dual issuable");
    w1c_keep_a: assert property (|ev_set |=> |ev_stat_r)
        else $error("Event lost");

    ffd_cov_c:   cover property (trig ##1 insn_valid && dec_nxt.fp_wb_block);
    bank_cov_c:  cover property (insn_valid && insn_code == 16'hFBFD);
    oc_cov_c:    cover property (oc_block);
    irq_cov_c:   cover property (irq);

endmodule

// ---- verification/fgd_fetch_model.sv ----
`timescale 1ns/1ps
module fgd_fetch_model (
    input  wire logic   aclk,
    output logic        insn_valid,
    output logic [15:0] insn_code,
    output logic        insn_cacheable,
    output logic        insn_translated
);
    initial {insn_valid, insn_code, insn_cacheable, insn_translated} = 19'h00003;
    // One word per clock, back to back
    task automatic word(input logic [15:0] c);
        @(posedge aclk);
        insn_valid <= 1'b1;
        insn_code  <= c;
    endtask
    task automatic idle();
        @(posedge aclk);
        insn_valid <= 1'b0;
        insn_code  <= ~insn_code;
    endtask
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd_d;
    logic              s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rd_r;
    logic              insn_valid, insn_cacheable, insn_translated, dec_valid, irq;
    logic              fp_bank_select_bit, fp_transfer_size_bit, icache_fill_inhibit, instruction_tlb_refill_inhibit;
    logic [15:0]       insn_code;
    fgd_pkg::fgd_dec_t dec;
    logic [6:0]        exp_q[$];
    integer            error_cnt = 0, checks = 0, seed = 32'hAA82FE28;
    int                inh_cnt = 0;
    localparam logic [15:0] NOP_C = 16'h0009;
    localparam logic [15:0] ORR0_C = 16'h200B;
    localparam logic [15:0] BASE [11] = '{16'hF10C, 16'hF01C, 16'hF11C, 16'hF108, 16'hF109, 16'hF106,
        16'hF01A, 16'hF01B, 16'hF017, 16'hF0ED, 16'hF1FD};
    localparam logic [15:0] MSK [11] = '{16'h0EE0, 16'h0EE0, 16'h0EE0, 16'h0EF0, 16'h0EF0, 16'h0EF0,
        16'h0FE0, 16'h0FE0, 16'h0FE0, 16'h0F00, 16'h0C00};
    always #12.5 aclk = ~aclk;
    fgd_fetch_model m (.aclk(aclk), .insn_valid(insn_valid), .insn_code(insn_code),
        .insn_cacheable(insn_cacheable), .insn_translated(insn_translated));
    fgd_insn_decoder dut (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
        while (aw | w)
        begin
            @(posedge aclk);
            aw = aw & (s_axi_awready !== 1'b1);
            w = w & (s_axi_wready !== 1'b1);
            {s_axi_awvalid, s_axi_wvalid} <= {aw, w};
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        {s_axi_arvalid, s_axi_rready} <= 2'h1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        {rd_d, rd_r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
    task automatic issue(input logic [15:0] c, input logic [6:0] e, input int pad, input logic [15:0] pc);
        exp_q.push_back(e);
        m.word(c);
        repeat (pad)
        begin
            exp_q.push_back(7'h00);
            m.word(pc);
        end
        m.idle();
        repeat (3) @(posedge aclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Decoded result against the oldest note
    always @(posedge aclk)
        if (dec_valid === 1'b1)
            chk({dec.op, dec.undef, dec.t_write, dec.privileged}, exp_q.pop_front());
    // Cycles with the icache fill inhibit raised plus cycles with the refill inhibit raised
    always @(posedge aclk)
        inh_cnt <= inh_cnt + icache_fill_inhibit + instruction_tlb_refill_inhibit;
    initial
    begin
        #200000;
        error_cnt++;
        give_verdict();
    end
    initial
    begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 44'h0000000000F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(fgd_pkg::CTRL_OFS);
        chk(rd_d, 32'h0);
        rd(4'h2);
        chk(rd_r, fgd_pkg::AXI_SLVERR);
        $display("Test reset done");
        wr(fgd_pkg::CTRL_OFS, 32'h2);
        for (int i = 0; i < 11; i++)
            issue(BASE[i] | (16'($random(seed)) & MSK[i]), {4'(i + 1), 3'h0}, 0, NOP_C);
        $display("Test decode done");
        issue(fgd_pkg::BANK_TGL_CODE, {fgd_pkg::FGD_OP_BANK_TGL, 3'h0}, 0, NOP_C);
        chk({fp_bank_select_bit, fp_transfer_size_bit}, 2'h3);
        issue(fgd_pkg::SIZE_TGL_CODE, {fgd_pkg::FGD_OP_SIZE_TGL, 3'h0}, 0, NOP_C);
        chk({fp_bank_select_bit, fp_transfer_size_bit}, 2'h2);
        rd(fgd_pkg::CTRL_OFS);
        chk(rd_d, 32'h1);
        $display("Test toggle done");
        wr(fgd_pkg::IRQ_MASK_OFS, 32'h0);
        wr(fgd_pkg::CTRL_OFS, 32'h38);
        issue(fgd_pkg::UNDEF_CODE, {fgd_pkg::FGD_OP_UNDEF, 3'h4}, 8, NOP_C);
        chk(inh_cnt, 2 * fgd_pkg::SHORT_WIN_I);
        chk(irq, 1'b0);
        wr(fgd_pkg::IRQ_MASK_OFS, 32'h1);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b1);
        wr(fgd_pkg::IRQ_STAT_OFS, 32'hF);
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        $display("Test undefined done");
        wr(fgd_pkg::CTRL_OFS, 32'h5);
        issue(16'hF00E | (16'($random(seed)) & 16'h0FF0), {fgd_pkg::FGD_OP_UNDEF, 3'h4}, 5, ORR0_C);
        exp_q.push_back({fgd_pkg::FGD_OP_UNDEF, 3'h4});
        m.word(fgd_pkg::UNDEF_CODE);
        issue(16'hF10E, {fgd_pkg::FGD_OP_UNDEF, 3'h4}, 0, NOP_C);
        rd(fgd_pkg::IRQ_STAT_OFS);
        chk(rd_d, 32'h9);
        $display("Test precision done");
        give_verdict();
    end
endmodule
